// [hw/pmc_power_ctrl.v]
/*
 Power mode controller: idle, stop and suspend sequencing, the power mode
 control register and a small oscillator/wake control set.
 Assumes the core pulses insn_done_in at each instruction boundary, all
 wake inputs synchronous to clk_in, and any device reset drives nrst_in.
*/
// How it works
// RULE_01: Idle bit halts core clock at boundary
// RULE_02: Idle keeps state, peripheral clocks stay on
// RULE_03: Enabled interrupt clears idle, core resumes
// RULE_04: Reset in any mode restarts from zero
// RULE_05: Software follows idle with multi-byte instruction
// RULE_06: Enabled watchdog expiry resets out of idle
// RULE_07: Stop bit halts oscillator, core, peripherals
// RULE_08: Stop leaves analog; only detector active
// RULE_09: Only reset leaves stop, never interrupts
// RULE_10: Missing-clock detector resets after stop timeout
// RULE_11: Suspend bit halts core and fast oscillator
// RULE_12: Suspend retains state; port match still watched
// RULE_13: Port match, comparator low, reset end suspend
// RULE_14: Suspend wake resumes next; handler runs first
// RULE_15: Firmware sets tempco enable before suspend
// RULE_16: Bits seven to two are plain flags
// RULE_17: Stop and idle bits read zero
// RULE_18: Wake restarts oscillator, holds core until ready
// RULE_19: Entry only at instruction completion boundary
`timescale 1ns/1ns
`include "pmc_defines.vh"
module pmc_power_ctrl #(
   parameter MCD_CYCLES   = `PMC_MCD_CYCLES,
   parameter OSC_START_CY = `PMC_OSC_START_CYC
) (
   input  wire        clk_in,            // System clock, 25 MHz
   input  wire        nrst_in,           // Any device reset, active low
   input  wire [7:0]  addr_in,           // Register address
   input  wire [7:0]  wdata_in,          // Register write data
   input  wire        wr_in,             // Write strobe
   input  wire        rd_in,             // Read strobe
   output reg  [7:0]  rdata_out,         // Read data, cycle after strobe
   input  wire        insn_done_in,      // Core instruction completes
   input  wire        irq_pending_in,    // Enabled interrupt asserted
   input  wire        wdt_enable_in,     // Watchdog enabled by software
   input  wire        wdt_expire_in,     // Watchdog expiry pulse
   input  wire        mcd_enable_in,     // Missing-clock detector enabled
   input  wire        port_match_in,     // Port match comparison hit
   input  wire        cmp_low_in,        // Comparator output low
   input  wire        osc_ready_in,      // Fast oscillator stable
   output wire        cpu_clk_en_out,    // Core clock enable
   output wire        periph_clk_en_out, // Digital peripheral clock enable
   output wire        int_osc_en_out,    // Internal fast oscillator enable
   output wire        irq_en_out,        // Interrupt logic active
   output wire        wdt_run_out,       // Watchdog may count
   output wire        port_match_en_out, // Port match logic active
   output wire        reset_req_out,     // Internal reset request
   output wire [2:0]  mode_out           // Current power mode
);
   reg [5:0] general_flags_q;
   reg       idle_req_q;
   reg       stop_req_q;
   reg       suspend_req_q;
   reg       zero_tempco_enable_q;
   reg       cmp_wake_en_q;
   reg [2:0] mode_q;
   reg [2:0] mode_d;
   reg [15:0] osc_cnt_q;
   reg       rst_req_q;
   wire      mcd_expired;
   wire      wr_pwr = wr_in && (addr_in == `PMC_OFF_POWER_CTRL);
   wire      wr_osc = wr_in && (addr_in == `PMC_OFF_OSC_CTRL);
   wire      wr_wake = wr_in && (addr_in == `PMC_OFF_WAKE_CTRL);
   wire      in_run = (mode_q == `PMC_MODE_RUN);
   wire      suspend_wake = port_match_in || (cmp_wake_en_q && cmp_low_in);  // RULE_13
   wire [15:0] osc_limit = OSC_START_CY[15:0];

   // Timeout in stop only; detector counts on its own slow source in silicon
   pmc_timeout #(
      .WIDTH (16),
      .LIMIT (MCD_CYCLES)
   ) u_mcd (
      .clk_in      (clk_in),
      .nrst_in     (nrst_in),
      .run_in      (mcd_enable_in && (mode_q == `PMC_MODE_STOP)),  // RULE_10
      .expired_out (mcd_expired)
   );

   // Register file
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         general_flags_q      <= 6'h00;
         idle_req_q           <= 1'b0;
         stop_req_q           <= 1'b0;
         suspend_req_q        <= 1'b0;
         zero_tempco_enable_q <= 1'b0;
         cmp_wake_en_q        <= 1'b0;
      end else begin
         if (wr_pwr) begin
            general_flags_q <= wdata_in[`PMC_GF_MSB:`PMC_GF_LSB];  // RULE_16
            idle_req_q      <= wdata_in[`PMC_BIT_IDLE];
            stop_req_q      <= wdata_in[`PMC_BIT_STOP];
         end else if (insn_done_in && in_run) begin
            // Request consumed at the boundary, so it never re-arms
            idle_req_q <= 1'b0;
            stop_req_q <= 1'b0;
         end
         if (wr_osc) begin
            suspend_req_q        <= wdata_in[`PMC_BIT_SUSPEND];
            zero_tempco_enable_q <= wdata_in[`PMC_BIT_ZTC_SEEN];  // RULE_15
         end else if (insn_done_in && in_run) begin
            suspend_req_q <= 1'b0;
         end
         if (wr_wake) begin
            cmp_wake_en_q <= wdata_in[`PMC_BIT_CMP_WAKE_EN];
         end
      end
   end

   // Mode sequencer
   always @* begin
      mode_d = mode_q;
      case (mode_q)
         `PMC_MODE_RUN: begin
            if (insn_done_in && !wr_pwr && !wr_osc) begin  // RULE_19
               if (stop_req_q) begin
                  mode_d = `PMC_MODE_STOP;  // RULE_07
               end else if (suspend_req_q) begin
                  mode_d = `PMC_MODE_SUSPEND;  // RULE_11
               end else if (idle_req_q) begin
                  mode_d = `PMC_MODE_IDLE;  // RULE_01
               end
            end
         end
         `PMC_MODE_IDLE: begin
            if (irq_pending_in) begin
               mode_d = `PMC_MODE_RUN;  // RULE_03
            end
         end
         `PMC_MODE_STOP: begin
            mode_d = `PMC_MODE_STOP;  // RULE_09
         end
         `PMC_MODE_SUSPEND: begin
            if (suspend_wake) begin
               mode_d = `PMC_MODE_OSC_WAIT;  // RULE_18
            end
         end
         `PMC_MODE_OSC_WAIT: begin
            if (osc_ready_in && (osc_cnt_q >= osc_limit)) begin
               mode_d = `PMC_MODE_RUN;  // RULE_14
            end
         end
         default: begin
            mode_d = `PMC_MODE_RUN;
         end
      endcase
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_q    <= `PMC_MODE_RUN;  // RULE_04
         osc_cnt_q <= 16'h0000;
         rst_req_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         if (mode_q == `PMC_MODE_OSC_WAIT) begin
            if (osc_cnt_q != osc_limit) begin
               osc_cnt_q <= osc_cnt_q + 16'h0001;
            end
         end else begin
            osc_cnt_q <= 16'h0000;
         end
         // Held until the external reset logic pulls nrst_in
         if ((mode_q == `PMC_MODE_IDLE) && wdt_enable_in && wdt_expire_in) begin
            rst_req_q <= 1'b1;  // RULE_06
         end else if (mcd_expired) begin
            rst_req_q <= 1'b1;  // RULE_10
         end
      end
   end

   // Read port
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            `PMC_OFF_POWER_CTRL: rdata_out <= {general_flags_q, 2'b00};  // RULE_17
            `PMC_OFF_OSC_CTRL:   rdata_out <= {2'b00, suspend_req_q, 4'h0, zero_tempco_enable_q};
            `PMC_OFF_WAKE_CTRL:  rdata_out <= {7'h00, cmp_wake_en_q};
            `PMC_OFF_STATUS:     rdata_out <= {4'h0, rst_req_q, mode_q};
            default:             rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // Register and memory clocks are never gated off; idle gates only the core, stop and suspend gate the peripherals too
   assign cpu_clk_en_out    = in_run;  // RULE_01
   assign periph_clk_en_out = in_run || (mode_q == `PMC_MODE_IDLE);  // RULE_02
   assign irq_en_out        = (mode_q != `PMC_MODE_STOP);  // RULE_08
   assign wdt_run_out       = wdt_enable_in && (in_run || (mode_q == `PMC_MODE_IDLE));  // RULE_06
   assign int_osc_en_out    = (mode_q != `PMC_MODE_STOP) && (mode_q != `PMC_MODE_SUSPEND);  // RULE_18
   assign port_match_en_out = (mode_q != `PMC_MODE_STOP);  // RULE_12
   assign reset_req_out     = rst_req_q;
   assign mode_out          = mode_q;
endmodule // pmc_power_ctrl

// [include/pmc_defines.vh]
/*
 Constants for the power mode controller: register offsets, field positions,
 reset values and timing counts. Assumes inclusion by bare name.
*/
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

`define PMC_ADDR_W           8
`define PMC_OFF_POWER_CTRL   8'h87
`define PMC_OFF_OSC_CTRL     8'h88
`define PMC_OFF_WAKE_CTRL    8'h89
`define PMC_OFF_STATUS       8'h8A
`define PMC_RST_POWER_CTRL   8'h00
`define PMC_RST_OSC_CTRL     8'h00
`define PMC_RST_WAKE_CTRL    8'h00

`define PMC_BIT_IDLE         0
`define PMC_BIT_STOP         1
`define PMC_GF_LSB           2
`define PMC_GF_MSB           7
`define PMC_BIT_SUSPEND      5
`define PMC_BIT_ZTC_SEEN     0
`define PMC_BIT_CMP_WAKE_EN  0

`define PMC_MODE_RUN         3'h0
`define PMC_MODE_IDLE        3'h1
`define PMC_MODE_STOP        3'h2
`define PMC_MODE_SUSPEND     3'h3
`define PMC_MODE_OSC_WAIT    3'h4

`define PMC_CLK_MHZ          25
`define PMC_MCD_TIMEOUT_US   100
`define PMC_MCD_CYCLES       (`PMC_MCD_TIMEOUT_US * `PMC_CLK_MHZ)
`define PMC_OSC_START_NS     1000
`define PMC_OSC_START_CYC    ((`PMC_OSC_START_NS * `PMC_CLK_MHZ + 999) / 1000)

`endif

// [hw/pmc_timeout.v]
/*
 Saturating timeout counter: counts while run_in is high, clears otherwise,
 and flags expiry. Assumes single synchronous clock domain.
*/
`timescale 1ns/1ns
module pmc_timeout #(
   parameter WIDTH = 16,
   parameter LIMIT = 2500
) (
   input  wire             clk_in,      // System clock
   input  wire             nrst_in,     // Async reset, active low
   input  wire             run_in,      // Count enable, clears when low
   output wire             expired_out  // Limit reached
);
   reg [WIDTH-1:0] count_q;
   wire [WIDTH-1:0] limit_w = LIMIT[WIDTH-1:0];

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count_q <= {WIDTH{1'b0}};
      end else if (!run_in) begin
         count_q <= {WIDTH{1'b0}};
      end else if (count_q != limit_w) begin
         count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign expired_out = run_in && (count_q == limit_w);
endmodule // pmc_timeout

// [verif/pmc_chk_chk.sv]
/*
 Concurrent checks on the power mode controller ports.
 Assumes a bind onto pmc_power_ctrl; one clock domain.
*/
`timescale 1ns/1ns
`include "pmc_defines.vh"
module pmc_chk (
   input wire       clk_in,            // Clock
   input wire       nrst_in,           // Reset
   input wire [7:0] addr_in,           // Address
   input wire       rd_in,             // Read strobe
   input wire [7:0] rdata_out,         // Read data
   input wire       insn_done_in,      // Boundary
   input wire       irq_pending_in,    // Interrupt
   input wire       wdt_enable_in,     // Watchdog on
   input wire       wdt_expire_in,     // Watchdog expiry
   input wire       port_match_in,     // Port match
   input wire       osc_ready_in,      // Oscillator up
   input wire       cpu_clk_en_out,    // Core clock
   input wire       periph_clk_en_out, // Peripheral clock
   input wire       int_osc_en_out,    // Oscillator on
   input wire       irq_en_out,        // Interrupts on
   input wire       port_match_en_out, // Port match on
   input wire       reset_req_out,     // Reset request
   input wire [2:0] mode_out           // Mode
);
   localparam logic [2:0] RUN = `PMC_MODE_RUN;
   localparam logic [2:0] IDL = `PMC_MODE_IDLE;
   localparam logic [2:0] STP = `PMC_MODE_STOP;
   localparam logic [2:0] SUS = `PMC_MODE_SUSPEND;
   localparam logic [2:0] OSW = `PMC_MODE_OSC_WAIT;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_susp_hit;
      mode_out == SUS && port_match_in;
   endsequence
   a_idle_clocks: assert property (mode_out == IDL |-> !cpu_clk_en_out && periph_clk_en_out && irq_en_out)
      else $error("idle clock enables wrong");
   a_idle_wake: assert property (mode_out == IDL && irq_pending_in |=> mode_out == RUN)
      else $error("idle did not end on interrupt");
   a_wdt_reset: assert property (mode_out == IDL && wdt_enable_in && wdt_expire_in |=> reset_req_out)
      else $error("watchdog expiry gave no reset");
   a_stop_gates: assert property (mode_out == STP |-> !int_osc_en_out && !irq_en_out && !periph_clk_en_out)
      else $error("stop gating wrong");
   a_stop_holds: assert property (mode_out == STP |=> mode_out == STP)
      else $error("stop left without reset");
   a_susp_keep: assert property (mode_out == SUS |-> port_match_en_out && !int_osc_en_out && !cpu_clk_en_out)
      else $error("suspend gating wrong");
   a_susp_wake: assert property (s_susp_hit |=> mode_out == OSW)
      else $error("port match did not wake");
   a_osc_hold: assert property (mode_out == OSW && !osc_ready_in |=> mode_out != RUN && !cpu_clk_en_out)
      else $error("core released before oscillator");
   a_entry_edge: assert property (mode_out == RUN && !insn_done_in |=> mode_out == RUN)
      else $error("mode left run off boundary");
   a_ctl_read: assert property (rd_in && addr_in == 8'h87 |=> rdata_out[1:0] == 2'h0)
      else $error("select bits read nonzero");
endmodule // pmc_chk
bind pmc_power_ctrl pmc_chk u_chk (.*);

// [verif/pmc_core_model.sv]
/*
 Core model: pulses an instruction boundary every third cycle.
 Assumes the core clock enable of the controller gates it.
*/
`timescale 1ns/1ns
module pmc_core_model (
   input  wire clk_in,        // Clock
   input  wire nrst_in,       // Reset
   input  wire cpu_en_in,     // Core clock enable
   output reg  insn_done_out  // Boundary pulse
);
   reg [1:0] cnt_q;
   // Multi-cycle instructions; boundaries ignore writes, the controller blocks entry on write cycles
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_q <= 2'h0;
         insn_done_out <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == 2'h2 || !cpu_en_in) ? 2'h0 : cnt_q + 2'h1;
         insn_done_out <= cpu_en_in && cnt_q == 2'h2;
      end
   end
endmodule // pmc_core_model

// [verif/power_mode_controller_test.sv]
/*
 Self-checking bench for the power mode controller.
 Assumes shortened detector and oscillator counts.
*/
`timescale 1ns/1ns
module power_mode_controller_test;
   logic clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, irq = 0, wdt_en = 0, wdt_exp = 0;
   logic mcd_en = 0, pm = 0, cmp = 0, osc_rdy = 0;
   logic [7:0] addr = 0, wdata = 0;
   wire [7:0] rdata;
   wire [2:0] mode;
   wire insn_done, cpu_en, per_en, osc_en, irq_en, pm_en, rst_req, wdt_run;
   int error_cnt = 0, tests_run = 0, cyc = 0, model_power_mode_control = 0, n, k;
   pmc_power_ctrl #(.MCD_CYCLES(20), .OSC_START_CY(3)) dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
      .insn_done_in(insn_done), .irq_pending_in(irq), .wdt_enable_in(wdt_en), .wdt_expire_in(wdt_exp),
      .mcd_enable_in(mcd_en), .port_match_in(pm), .cmp_low_in(cmp), .osc_ready_in(osc_rdy),
      .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en), .int_osc_en_out(osc_en), .irq_en_out(irq_en),
      .wdt_run_out(wdt_run), .port_match_en_out(pm_en), .reset_req_out(rst_req), .mode_out(mode));
   pmc_core_model core (.clk_in(clk_in), .nrst_in(nrst_in), .cpu_en_in(cpu_en), .insn_done_out(insn_done));
   initial forever #20 clk_in = ~clk_in;
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in) {wr_in, addr, wdata} <= {1'b1, a, d};
      @(posedge clk_in) wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in) {rd_in, addr} <= {1'b1, a};
      @(posedge clk_in) rd_in <= 1'b0;
      #1 chk(exp, rdata);
   endtask
   task automatic wait_mode(input logic [2:0] m);
      for (n = 0; n < 100 && mode !== m; n++) @(posedge clk_in);
      #1 chk({5'h00, m}, {5'h00, mode});
   endtask
   task automatic do_reset;
      nrst_in <= 1'b0;
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      model_power_mode_control = 0;
   endtask
   task final_report;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      void'($urandom(19245));
      do_reset();
      rd(8'h87, 8'h00);
      rd(8'h90, 8'h00);
      repeat (4) begin
         model_power_mode_control = $urandom & 8'hFC;
         wr(8'h87, model_power_mode_control[7:0]);
         rd(8'h87, model_power_mode_control[7:0]);
      end
      $display("flags test done");
      wr(8'h87, model_power_mode_control[7:0] | 8'h01);
      wait_mode(3'h1);
      chk(8'h01, {6'h00, cpu_en, per_en});
      @(posedge clk_in) irq <= 1'b1;
      wait_mode(3'h0);
      irq <= 1'b0;
      rd(8'h87, model_power_mode_control[7:0]);
      wdt_en <= 1'b1;
      wr(8'h87, 8'h01);
      wait_mode(3'h1);
      chk(8'h01, {7'h00, wdt_run});
      @(posedge clk_in) wdt_exp <= 1'b1;
      @(posedge clk_in) wdt_exp <= 1'b0;
      #1 chk(8'h01, {7'h00, rst_req});
      do_reset();
      wdt_en <= 1'b0;
      rd(8'h87, 8'h00);
      chk(8'h00, {4'h0, rst_req, mode});
      $display("idle test done");
      wr(8'h87, 8'h02);
      wait_mode(3'h2);
      chk(8'h00, {4'h0, osc_en, irq_en, cpu_en, per_en});
      chk(8'h00, {7'h00, wdt_run});
      @(posedge clk_in) irq <= 1'b1;
      repeat (5) @(posedge clk_in);
      irq <= 1'b0;
      mcd_en <= 1'b1;
      #1 chk(8'h02, {5'h00, mode});
      for (n = 0; n < 50 && rst_req !== 1'b1; n++) @(posedge clk_in);
      chk(8'h01, {7'h00, n >= 19 && n <= 23});
      do_reset();
      mcd_en <= 1'b0;
      $display("stop test done");
      for (k = 0; k < 2; k++) begin
         wr(8'h89, k[7:0]);
         wr(8'h88, 8'h21);
         wait_mode(3'h3);
         chk(8'h04, {5'h00, pm_en, osc_en, cpu_en});
         @(posedge clk_in) cmp <= 1'b1;
         if (k == 0) begin
            repeat (3) @(posedge clk_in);
            #1 chk(8'h03, {5'h00, mode});
            pm <= 1'b1;
         end
         wait_mode(3'h4);
         repeat (5) @(posedge clk_in);
         #1 chk(8'h04, {5'h00, mode});
         @(posedge clk_in) osc_rdy <= 1'b1;
         wait_mode(3'h0);
         {pm, cmp, osc_rdy} <= 3'h0;
         rd(8'h88, 8'h01);
      end
      $display("suspend test done");
      final_report();
   end
endmodule // power_mode_controller_test
